/* ext_irq_pkg.sv */
`default_nettype none
package ext_irq_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_ENABLE_MASK = 8'h3B;
  localparam logic [7:0] IDX_FLAGS = 8'h3C;
  localparam logic [7:0] IDX_SENSE = 8'h3D;
  localparam logic [7:0] IDX_MASK_HIGH = 8'h3E;
  localparam logic [7:0] IDX_MASK_LOW = 8'h3F;
  localparam logic [7:0] IDX_STATUS_WORD = 8'h40;

  // width of the index field and the byte-lane shift that turns it into an address
  localparam int IDX_W = 8;
  localparam int ADDR_W = 12;
  localparam int LANE_SHIFT = 2;

  // bit positions in interrupt_enable_mask and interrupt_flags
  localparam int BIT_EXT = 6;
  localparam int BIT_GROUP_HIGH_EN = 5;
  localparam int BIT_GROUP_LOW_EN = 4;
  localparam int BIT_GROUP_HIGH_FLAG = 1;
  localparam int BIT_GROUP_LOW_FLAG = 0;

  // global interrupt enable position in core_status_word
  localparam int BIT_GLOBAL_EN = 7;

  // implemented-bit masks; everything else reads zero
  localparam logic [7:0] ENABLE_MASK_RW = 8'h70;
  localparam logic [7:0] FLAGS_RW = 8'h43;
  localparam logic [7:0] SENSE_RW = 8'h03;
  localparam logic [7:0] MASK_HIGH_RW = 8'h0F;
  localparam logic [7:0] MASK_LOW_RW = 8'hFF;
  localparam logic [7:0] STATUS_WORD_RW = 8'h80;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // pin counts
  localparam int N_PC = 12;
  localparam int N_LOW = 8;
  localparam int N_HIGH = 4;

  // sense-control encodings
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY_CHANGE = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_RISING = 2'h3;

  // vector addresses presented to the core
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_EXT = 16'h0001;
  localparam logic [15:0] VEC_GROUP_LOW = 16'h0002;
  localparam logic [15:0] VEC_GROUP_HIGH = 16'h0003;

endpackage
`default_nettype wire

/* external_pin_interrupts.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - interrupts fire even when pins drive outputs
// - group low requests on enabled pins 7:0 toggling
// - group high requests on enabled pins 11:8 toggling
// - pin-change detection clockless, wakes any sleep
// - level mode requests while pin stays low
// - pin edges detected only with io clock
// - low-level detection clockless, wakes any sleep
// - level gone before wake: no interrupt
// - sense field 00 low,01 any,10 fall,11 rise
// - pin sampled first; longer-than-clock pulses caught
// - mask bit 6 with global enables pin
// - mask bits 5,4 enable groups with global
// - reserved mask and flag bits read zero
// - flag 6 sets on trigger, clears vector/write-one
// - flag 6 reads zero in level mode
// - flags 1,0 set on group change, clear likewise
// - pin mask bit works only with group enable
// - vectors 0x0001 pin, 0x0002 low, 0x0003 high
module external_pin_interrupts (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, sampled as seen on the pad whatever their direction
  input wire logic ext_irq_pin,
  input wire logic [11:0] pin_change_input,
  // io clock running; edge sensing stalls while low
  input wire logic io_clk_en,
  // core side
  input wire logic vector_ack,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic wake_req
);

  // whole state of the block
  typedef struct packed {
    logic [7:0] enable_mask; // bits 6..4 live
    logic [1:0] sense_control; // trigger selection for the pin
    logic ext_pin_flag; // sticky pin event
    logic group_high_flag; // sticky group high event
    logic group_low_flag; // sticky group low event
    logic [3:0] mask_high; // per-pin enables for 11:8
    logic [7:0] mask_low; // per-pin enables for 7:0
    logic global_en; // global interrupt flag of the core
    logic ext_prev; // last sampled pin level for edges
    logic [11:0] pc_prev; // last sampled pin-change levels
    logic primed; // history valid after first sample
    logic pready; // apb answer
    logic [31:0] prdata; // apb read data
    logic pslverr; // apb error answer
    logic irq_req; // request to the core
    logic [15:0] irq_vector; // vector being requested
    logic wake_req; // wake request to sleep control
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  // sizes derived from the package for the index field, the synchroniser and the address padding
  localparam int IDX_W_L = ext_irq_pkg::IDX_W;
  // the dedicated pin rides on top of the pin-change bank in one synchroniser
  localparam int EXT_POS = ext_irq_pkg::N_PC;
  localparam int SYNC_W = ext_irq_pkg::N_PC + 1;
  // zero padding between the register index and the full byte address
  localparam int PAD_W = ext_irq_pkg::ADDR_W - IDX_W_L;

  logic [12:0] pins_raw; // pins before synchronising
  logic [12:0] pins_sync; // pins after two flops
  logic ext_now; // synchronised dedicated pin
  logic [11:0] pc_now; // synchronised pin-change inputs

  // combinational helpers, derived from the current state, the synchronised pins, io_clk_en and the bus;
  // none of them is registered, so every output still comes from a flop
  logic access; // apb access phase
  logic commit; // edge where the transfer completes
  logic [IDX_W_L-1:0] reg_idx; // decoded register index
  logic hit; // address maps to a register
  logic [7:0] wbyte; // write data low byte
  logic wr_lane; // low byte lane enabled
  logic [7:0] rd_byte; // read mux result
  logic ext_edge; // edge event on the pin per sense mode
  logic level_mode; // sense control selects low level
  logic level_active; // enabled low level present
  logic [11:0] pc_change; // per-pin toggle, masked
  logic low_event; // any enabled toggle in 7:0
  logic high_event; // any enabled toggle in 11:8
  logic ext_set; // set for the pin flag
  logic low_set; // set for group low flag
  logic high_set; // set for group high flag
  logic ext_pend; // pin request pending
  logic low_pend; // group low request pending
  logic high_pend; // group high request pending

  // both pin paths cross into pclk through one synchroniser bank;
  // one shared bank keeps the crossing uniform, at the cost of two cycles
  // of latency on every pin event; pulses shorter than one clock may be lost
  assign pins_raw = {ext_irq_pin, pin_change_input};

  pin_sync #(
    .WIDTH(SYNC_W)
  ) pin_sync_i (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pins_raw),
    .pins_sync(pins_sync)
  );

  assign ext_now = pins_sync[EXT_POS];
  assign pc_now = pins_sync[EXT_POS-1:0];

  // byte address of a register from its index
  // the shift stays inside the address width for every index in use
  function automatic logic [ext_irq_pkg::ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {{PAD_W{1'b0}}, idx} << ext_irq_pkg::LANE_SHIFT;
  endfunction

  // true when the bus address names the given register
  // a full compare, so aliases and unaligned byte addresses never hit
  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] idx);
    addr_is = (a == {{(32 - ext_irq_pkg::ADDR_W){1'b0}}, reg_addr(idx)});
  endfunction

  // apb decode; unaligned or unknown addresses get an error answer
  // a single fixed wait state keeps read data registered; the slave never
  // stalls longer, so a master needs no timeout of its own for this block
  always_comb begin
    access = psel && penable;
    commit = access && cur_ff.pready;
    reg_idx = paddr[ext_irq_pkg::LANE_SHIFT +: IDX_W_L];
    hit = addr_is(paddr, ext_irq_pkg::IDX_ENABLE_MASK)
       || addr_is(paddr, ext_irq_pkg::IDX_FLAGS)
       || addr_is(paddr, ext_irq_pkg::IDX_SENSE)
       || addr_is(paddr, ext_irq_pkg::IDX_MASK_HIGH)
       || addr_is(paddr, ext_irq_pkg::IDX_MASK_LOW)
       || addr_is(paddr, ext_irq_pkg::IDX_STATUS_WORD);
    wbyte = pwdata[7:0];
    wr_lane = pstrb[0];
  end

  // read mux; unused bits held at zero by the masks
  // reserved bits are forced here rather than trusted to stored values
  always_comb begin
    rd_byte = ext_irq_pkg::RESET_BYTE;
    if (!hit) begin
      rd_byte = ext_irq_pkg::RESET_BYTE;
    end else if (reg_idx == ext_irq_pkg::IDX_ENABLE_MASK) begin
      rd_byte = cur_ff.enable_mask & ext_irq_pkg::ENABLE_MASK_RW;
    end else if (reg_idx == ext_irq_pkg::IDX_FLAGS) begin
      rd_byte = ext_irq_pkg::RESET_BYTE;
      rd_byte[ext_irq_pkg::BIT_EXT] = cur_ff.ext_pin_flag;
      rd_byte[ext_irq_pkg::BIT_GROUP_HIGH_FLAG] = cur_ff.group_high_flag;
      rd_byte[ext_irq_pkg::BIT_GROUP_LOW_FLAG] = cur_ff.group_low_flag;
    end else if (reg_idx == ext_irq_pkg::IDX_SENSE) begin
      rd_byte = {6'h00, cur_ff.sense_control};
    end else if (reg_idx == ext_irq_pkg::IDX_MASK_HIGH) begin
      rd_byte = {4'h0, cur_ff.mask_high};
    end else if (reg_idx == ext_irq_pkg::IDX_MASK_LOW) begin
      rd_byte = cur_ff.mask_low;
    end else begin
      rd_byte = ext_irq_pkg::RESET_BYTE;
      rd_byte[ext_irq_pkg::BIT_GLOBAL_EN] = cur_ff.global_en;
    end
  end

  // event detection on the synchronised pins
  // history is primed once after reset so levels present at release are
  // not mistaken for changes; the enables are all clear at that point,
  // which covers the cycles while the synchroniser still fills
  always_comb begin
    level_mode = (cur_ff.sense_control == ext_irq_pkg::SENSE_LOW_LEVEL);
    // edges only advance while the io clock runs
    ext_edge = 1'b0;
    if (io_clk_en && cur_ff.primed) begin
      case (cur_ff.sense_control)
        ext_irq_pkg::SENSE_ANY_CHANGE: ext_edge = (ext_now != cur_ff.ext_prev);
        ext_irq_pkg::SENSE_FALLING: ext_edge = cur_ff.ext_prev && !ext_now;
        ext_irq_pkg::SENSE_RISING: ext_edge = !cur_ff.ext_prev && ext_now;
        default: ext_edge = 1'b0;
      endcase
    end
    // live level, never latched, so a level that vanishes leaves nothing
    level_active = level_mode && !ext_now
                && cur_ff.enable_mask[ext_irq_pkg::BIT_EXT];
    // toggle per pin, masked by pin and group enables
    pc_change = (pc_now ^ cur_ff.pc_prev) & {12{cur_ff.primed}};
    pc_change[7:0] = pc_change[7:0] & cur_ff.mask_low
                   & {8{cur_ff.enable_mask[ext_irq_pkg::BIT_GROUP_LOW_EN]}};
    pc_change[11:8] = pc_change[11:8] & cur_ff.mask_high
                    & {4{cur_ff.enable_mask[ext_irq_pkg::BIT_GROUP_HIGH_EN]}};
    low_event = |pc_change[7:0];
    high_event = |pc_change[11:8];
    // pin direction plays no part: a driven pin loops back through its pad
    ext_set = ext_edge && !level_mode;
    low_set = low_event;
    high_set = high_event;
  end

  // request qualification with enables and the global flag
  // flags are kept even with the global flag clear, so software can poll
  // them and a request appears as soon as the global flag is set again
  always_comb begin
    ext_pend = cur_ff.global_en && cur_ff.enable_mask[ext_irq_pkg::BIT_EXT]
            && (level_active || (cur_ff.ext_pin_flag && !level_mode));
    low_pend = cur_ff.global_en && cur_ff.group_low_flag
            && cur_ff.enable_mask[ext_irq_pkg::BIT_GROUP_LOW_EN];
    high_pend = cur_ff.global_en && cur_ff.group_high_flag
             && cur_ff.enable_mask[ext_irq_pkg::BIT_GROUP_HIGH_EN];
  end

  // next-state logic
  // order matters below: bus writes, then vector clears, then event sets,
  // then the level-mode override, each one able to overrule the last
  always_comb begin
    nxt_ff = cur_ff;

    // history for edge and toggle comparison
    nxt_ff.primed = 1'b1;
    nxt_ff.pc_prev = pc_now;
    if (io_clk_en || !cur_ff.primed) begin
      nxt_ff.ext_prev = ext_now;
    end

    // one wait state: data registered in the first access cycle
    nxt_ff.pready = access && !cur_ff.pready;
    if (access && !cur_ff.pready) begin
      nxt_ff.prdata = {24'h000000, pwrite ? ext_irq_pkg::RESET_BYTE : rd_byte};
      nxt_ff.pslverr = !hit;
    end else if (commit) begin
      nxt_ff.pslverr = 1'b0;
    end

    // register writes take effect on the completing edge
    // only the low byte lane carries a register; a write without it is
    // acknowledged but changes nothing, so wide stores cannot half-land
    if (commit && pwrite && hit && wr_lane) begin
      if (reg_idx == ext_irq_pkg::IDX_ENABLE_MASK) begin
        nxt_ff.enable_mask = wbyte & ext_irq_pkg::ENABLE_MASK_RW;
      end else if (reg_idx == ext_irq_pkg::IDX_SENSE) begin
        nxt_ff.sense_control = wbyte[1:0] & ext_irq_pkg::SENSE_RW[1:0];
      end else if (reg_idx == ext_irq_pkg::IDX_MASK_HIGH) begin
        nxt_ff.mask_high = wbyte[3:0] & ext_irq_pkg::MASK_HIGH_RW[3:0];
      end else if (reg_idx == ext_irq_pkg::IDX_MASK_LOW) begin
        nxt_ff.mask_low = wbyte & ext_irq_pkg::MASK_LOW_RW;
      end else if (reg_idx == ext_irq_pkg::IDX_STATUS_WORD) begin
        nxt_ff.global_en = wbyte[ext_irq_pkg::BIT_GLOBAL_EN];
      end else if (reg_idx == ext_irq_pkg::IDX_FLAGS) begin
        // write one to clear
        if (wbyte[ext_irq_pkg::BIT_EXT]) begin
          nxt_ff.ext_pin_flag = 1'b0;
        end
        if (wbyte[ext_irq_pkg::BIT_GROUP_HIGH_FLAG]) begin
          nxt_ff.group_high_flag = 1'b0;
        end
        if (wbyte[ext_irq_pkg::BIT_GROUP_LOW_FLAG]) begin
          nxt_ff.group_low_flag = 1'b0;
        end
      end
    end

    // vectoring clears the flag of the vector that was presented
    // the core acknowledges what it saw on the last edge, so the clear
    // follows the vector shown now, not the one about to be shown
    if (vector_ack && cur_ff.irq_req) begin
      if (cur_ff.irq_vector == ext_irq_pkg::VEC_EXT) begin
        nxt_ff.ext_pin_flag = 1'b0;
      end else if (cur_ff.irq_vector == ext_irq_pkg::VEC_GROUP_LOW) begin
        nxt_ff.group_low_flag = 1'b0;
      end else if (cur_ff.irq_vector == ext_irq_pkg::VEC_GROUP_HIGH) begin
        nxt_ff.group_high_flag = 1'b0;
      end
    end

    // sets come last so an event in the clearing cycle survives
    if (ext_set) begin
      nxt_ff.ext_pin_flag = 1'b1;
    end
    if (low_set) begin
      nxt_ff.group_low_flag = 1'b1;
    end
    if (high_set) begin
      nxt_ff.group_high_flag = 1'b1;
    end
    // level mode keeps the pin flag cleared whatever happened above
    if (nxt_ff.sense_control == ext_irq_pkg::SENSE_LOW_LEVEL) begin
      nxt_ff.ext_pin_flag = 1'b0;
    end

    // fixed priority: lowest vector address wins
    // a lower source held pending starves the others until it is served
    nxt_ff.irq_req = ext_pend || low_pend || high_pend;
    if (ext_pend) begin
      nxt_ff.irq_vector = ext_irq_pkg::VEC_EXT;
    end else if (low_pend) begin
      nxt_ff.irq_vector = ext_irq_pkg::VEC_GROUP_LOW;
    end else if (high_pend) begin
      nxt_ff.irq_vector = ext_irq_pkg::VEC_GROUP_HIGH;
    end else begin
      nxt_ff.irq_vector = ext_irq_pkg::VEC_NONE;
    end

    // wake needs no io clock and ignores the global flag;
    // limitation: this model still sees it through the pclk synchroniser
    nxt_ff.wake_req = level_active || low_event || high_event;
  end

  // single state register
  // reset clears every field, which leaves the pin in level mode, disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs straight from flops
  // no logic between state and pins, so outputs never glitch
  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign irq_req = cur_ff.irq_req;
  assign irq_vector = cur_ff.irq_vector;
  assign wake_req = cur_ff.wake_req;

endmodule
`default_nettype wire

/* external_pin_interrupts_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// port-level checks; three config fields are shadowed from completed writes
module ext_irq_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ext_irq_pin,
  input wire logic [11:0] pin_change_input,
  input wire logic io_clk_en,
  input wire logic vector_ack,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic wake_req
);
  logic [1:0] sense_ff; // shadow of the sense field
  logic ext_en_ff; // shadow of the pin enable
  logic glob_ff; // shadow of the global enable
  logic wr; // a write lands this edge
  logic lvl_on; // pin enabled in level mode
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  assign lvl_on = ext_en_ff && sense_ff == 2'h0;
  // shadows update at the same edge as the design's registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_ff <= 2'h0;
      ext_en_ff <= 1'b0;
      glob_ff <= 1'b0;
    end else if (wr) begin
      if (paddr == 32'h000000F4) sense_ff <= pwdata[1:0];
      if (paddr == 32'h000000EC) ext_en_ff <= pwdata[6];
      if (paddr == 32'h00000100) glob_ff <= pwdata[7];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
  a_mask_reserved: assert property (
    pready && !pwrite && paddr == 32'h000000EC |-> (prdata[7:0] & 8'h8F) == 8'h00)
    else $error("reserved enable bits set");
  a_flag_reserved: assert property (
    pready && !pwrite && paddr == 32'h000000F0 |-> (prdata[7:0] & 8'hBC) == 8'h00)
    else $error("reserved flag bits set");
  a_level_flag_zero: assert property (
    pready && !pwrite && paddr == 32'h000000F0 && sense_ff == 2'h0 |-> !prdata[6])
    else $error("pin flag set in level mode");
  a_vector_known: assert property (
    irq_req |-> irq_vector inside {16'h0001, 16'h0002, 16'h0003})
    else $error("bad vector");
  a_level_request: assert property (
    (lvl_on && glob_ff && !ext_irq_pin) [*5] |-> irq_req && irq_vector == 16'h0001)
    else $error("level request missing");
  a_level_wake: assert property (
    (lvl_on && !ext_irq_pin) [*5] |-> wake_req) else $error("level wake missing");
  a_global_quiet: assert property (
    !glob_ff [*3] |-> !irq_req) else $error("request without global enable");
endmodule
bind external_pin_interrupts ext_irq_chk ext_irq_chk_i (.*);
`default_nettype wire

/* external_pin_interrupts_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module external_pin_interrupts_bench;
  localparam logic [7:0] EN = ext_irq_pkg::IDX_ENABLE_MASK;
  localparam logic [7:0] FLG = ext_irq_pkg::IDX_FLAGS;
  localparam logic [7:0] SEN = ext_irq_pkg::IDX_SENSE;
  localparam logic [7:0] MH = ext_irq_pkg::IDX_MASK_HIGH;
  localparam logic [7:0] ML = ext_irq_pkg::IDX_MASK_LOW;
  localparam logic [7:0] ST = ext_irq_pkg::IDX_STATUS_WORD;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic io_clk_en = 1'b1;
  logic vector_ack = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_irq_pin, irq_req, wake_req;
  logic [11:0] pin_change_input;
  logic [15:0] irq_vector;
  logic [7:0] rd; // last read byte
  logic err_seen; // last error response
  logic [7:0] regs [6] = '{EN, SEN, MH, ML, ST, FLG};
  logic [7:0] rwm [5] = '{8'h70, 8'h03, 8'h0F, 8'hFF, 8'h80}; // implemented bits
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #10 pclk = ~pclk;
  external_pin_interrupts external_pin_interrupts_i (.*);
  pin_source pin_source_i (.pclk(pclk), .ext_irq_pin(ext_irq_pin),
    .pin_change_input(pin_change_input));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; the register index maps to a word address
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(what, rd, exp);
  endtask
  // waits are bounded by the cycle ceiling below
  task automatic wait_req;
    while (irq_req !== 1'b1) @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rdchk("reset value", regs[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, regs[i], 8'hFF);
      rdchk("write mask", regs[i], rwm[i]);
    end
    apb(1'b0, 8'h00, 8'h00);
    check("unmapped error", err_seen, 1'b1);
    check("unmapped data", rd, 8'h00);
    // a write with the low byte lane off leaves the register alone
    pstrb <= 4'hE;
    apb(1'b1, ML, 8'h00);
    pstrb <= 4'hF;
    rdchk("lane off", ML, 8'hFF);
    // group low: an unmasked pin stays silent, a masked-in pin requests
    apb(1'b1, ML, 8'h01);
    apb(1'b1, EN, 8'h10);
    apb(1'b1, FLG, 8'hFF);
    pin_source_i.flip(1, 4);
    rdchk("masked pin", FLG, 8'h00);
    pin_source_i.flip(0, 4);
    wait_req();
    check("low vector", irq_vector, 16'h0002);
    rdchk("low flag", FLG, 8'h01);
    apb(1'b1, FLG, 8'h01);
    rdchk("low clear", FLG, 8'h00);
    // group high, cleared by the core taking the vector
    apb(1'b1, EN, 8'h00);
    pin_source_i.flip(8, 4);
    rdchk("group off", FLG, 8'h00);
    apb(1'b1, EN, 8'h20);
    pin_source_i.flip(8, 4);
    wait_req();
    check("high vector", irq_vector, 16'h0003);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    rdchk("ack clear", FLG, 8'h00);
    check("request gone", irq_req, 1'b0);
    check("vector none", irq_vector, 16'h0000);
    // every edge mode on the dedicated pin, fall then rise
    apb(1'b1, ST, 8'h00);
    apb(1'b1, EN, 8'h40);
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, SEN, s[7:0]);
      apb(1'b1, FLG, 8'h40);
      pin_source_i.set_ext(1'b0, 4);
      rdchk("after fall", FLG, (s != 3) ? 8'h40 : 8'h00);
      apb(1'b1, FLG, 8'h40);
      pin_source_i.set_ext(1'b1, 4);
      rdchk("after rise", FLG, (s != 2) ? 8'h40 : 8'h00);
    end
    // a falling edge with the io clock stopped is not seen
    apb(1'b1, SEN, 8'h02);
    apb(1'b1, FLG, 8'h40);
    io_clk_en <= 1'b0;
    pin_source_i.set_ext(1'b0, 4);
    rdchk("stopped clock", FLG, 8'h00);
    io_clk_en <= 1'b1;
    pin_source_i.set_ext(1'b1, 4);
    // level mode: live request while low, none once released
    apb(1'b1, SEN, 8'h00);
    apb(1'b1, ST, 8'h80);
    pin_source_i.set_ext(1'b0, 6);
    check("level request", irq_req, 1'b1);
    check("level vector", irq_vector, 16'h0001);
    check("level wake", wake_req, 1'b1);
    rdchk("level flag", FLG, 8'h00);
    pin_source_i.set_ext(1'b1, 6);
    check("level gone", irq_req, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire

/* pin_source.sv */
`timescale 1ns/1ns
`default_nettype none
// far side: drives the pads, holding each level long enough to be sampled
module pin_source (
  input wire logic pclk,
  output logic ext_irq_pin,
  output logic [11:0] pin_change_input
);
  // idle high on the dedicated pin, as with a pull-up
  initial begin
    ext_irq_pin = 1'b1;
    pin_change_input = 12'h000;
  end
  // set the dedicated pin and hold it for hold cycles
  task automatic set_ext(input logic v, input int hold);
    ext_irq_pin <= v;
    repeat (hold) @(posedge pclk);
  endtask
  // toggle one pin-change pad and hold it
  task automatic flip(input int idx, input int hold);
    pin_change_input[idx] <= ~pin_change_input[idx];
    repeat (hold) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for a bundle of asynchronous pins
module pin_sync #(
  parameter int WIDTH = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] pins_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta; // first stage, read only by the second
    logic [WIDTH-1:0] stable; // second stage, safe for logic
  } sync_s;

  sync_s cur_ff;
  sync_s nxt_ff;

  // shift the pins through both stages
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.meta = pins;
    nxt_ff.stable = cur_ff.meta;
  end

  // constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign pins_sync = cur_ff.stable;

endmodule
`default_nettype wire
